// File: src/kwdt_pkg.sv
// package: register map, field layout, reset values and timing for the keyed watchdog
package kwdt_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] ADDR_WDT_CTRL = 3'h0;
  localparam logic [2:0] ADDR_RST_FLAGS = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h3;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // watchdog_control fields
  localparam int KEY_LSB = 3;
  localparam int KEY_W = 5;
  localparam int SEL_W = 3;
  localparam logic [KEY_W-1:0] KEY_DISABLE = 5'h15;
  localparam logic [KEY_W-1:0] KEY_ENABLE = 5'h0A;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h3;
  localparam logic [DATA_W-1:0] WDT_CTRL_RESET = 8'h53;

  // system_reset_flags bit positions
  localparam int BIT_IDLE_KEEP = 7;
  localparam int BIT_BROWNOUT = 2;
  localparam int BIT_VSEL_FAULT = 1;
  localparam int BIT_KEY_FAULT = 0;

  // status bits
  localparam int BIT_EXPIRY = 0;
  localparam int BIT_POWERDOWN = 1;

  // interrupt event bits
  localparam int IRQ_W = 3;
  localparam int IRQ_OVERFLOW = 0;
  localparam int IRQ_KEYFAULT = 1;
  localparam int IRQ_WAKE = 2;

  // prescaler: 19 bits hold the 2^18 limit
  localparam int CNT_W = 19;
  // key fault reset fires after this many rc clock cycles (2 to 3)
  localparam logic [1:0] KEY_FAULT_TICKS = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } kwdt_bus_t;

  typedef struct packed {
    logic halt;
    logic kick;
    logic idle_mode;
  } kwdt_cpu_t;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP} kwdt_state_t;

  // exponent of the time-out for each period_select code
  function automatic logic [4:0] kwdt_exp(input logic [SEL_W-1:0] sel);
    case (sel)
      3'h0: kwdt_exp = 5'h08;
      3'h1: kwdt_exp = 5'h0A;
      3'h2: kwdt_exp = 5'h0C;
      3'h3: kwdt_exp = 5'h0E;
      3'h4: kwdt_exp = 5'h0F;
      3'h5: kwdt_exp = 5'h10;
      3'h6: kwdt_exp = 5'h11;
      default: kwdt_exp = 5'h12;
    endcase
  endfunction
endpackage

// File: src/kwdt_top.sv
// keyed watchdog timer: prescaled slow-clock counter, key check, reset flags
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Summary of operation
// ---------------------------------------------------------------
module kwdt_top
  import kwdt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic slow_tick_i,
  input wire logic rc_tick_i,
  input wire logic src_is_crystal_i,
  input wire logic halt_i,
  input wire logic kick_i,
  input wire logic idle_mode_i,
  input wire logic brownout_evt_i,
  input wire logic vsel_fault_evt_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic device_reset_o,
  output logic pc_sp_reset_o,
  output logic wake_o,
  output logic slow_clk_en_o,
  output logic idle_sysclk_keep_o,
  output logic irq_o
);
  kwdt_bus_t bus;
  kwdt_cpu_t cpu;
  kwdt_state_t state_ff;
  logic [DATA_W-1:0] ctrl_ff;
  logic key_fault_ff;
  logic vsel_fault_ff;
  logic brownout_ff;
  logic idle_keep_ff;
  logic expiry_ff;
  logic powerdown_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [1:0] fault_cnt_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic dev_rst_ff;
  logic pcsp_rst_ff;
  logic wake_ff;
  logic slow_en_ff;
  logic irq_ff;
  logic [KEY_W-1:0] key;
  logic wdt_on;
  logic key_bad;
  logic overflow;
  logic fault_fire;
  logic [CNT_W-1:0] limit;
  logic [IRQ_W-1:0] irq_evt;
  logic [DATA_W-1:0] nxt_rdata;
  logic at_limit;
  logic cnt_clear;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_mask;
  logic rd_irq;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign cpu = '{halt: halt_i, kick: kick_i, idle_mode: idle_mode_i};
  assign key = ctrl_ff[KEY_LSB +: KEY_W];
  assign wdt_on = (key == KEY_ENABLE);
  assign key_bad = (key != KEY_ENABLE) && (key != KEY_DISABLE);
  assign limit = CNT_W'(1) << kwdt_exp(ctrl_ff[SEL_W-1:0]);
  assign at_limit = (cnt_ff == limit - CNT_W'(1));
  // kick and halt restart the count, so an overflow on that edge is dropped
  assign cnt_clear = cpu.kick || cpu.halt;
  // overflow when the count reaches the selected power of two
  assign overflow = wdt_on && slow_tick_i && at_limit && !cnt_clear;
  assign fault_fire = key_bad && rc_tick_i && (fault_cnt_ff == KEY_FAULT_TICKS);
  assign irq_evt = {overflow && (state_ff == ST_SLEEP), fault_fire, overflow};

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  assign wr_ctrl = bus.wr && (bus.addr == ADDR_WDT_CTRL);
  assign wr_flags = bus.wr && (bus.addr == ADDR_RST_FLAGS);
  assign wr_mask = bus.wr && (bus.addr == ADDR_IRQ_MASK);
  assign rd_irq = bus.rd && (bus.addr == ADDR_IRQ_STAT);

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_ff <= WDT_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // run / sleep state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= ST_RUN;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (cpu.halt) begin
            state_ff <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (overflow || cpu.kick || fault_fire) begin
            state_ff <= ST_RUN;
          end
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // prescaler counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_ff <= '0;
    end else if (cpu.kick) begin
      cnt_ff <= '0;
    end else if (cpu.halt || fault_fire) begin
      cnt_ff <= '0;
    end else if (!wdt_on) begin
      cnt_ff <= '0;
    end else if (overflow) begin
      cnt_ff <= '0;
    end else if (slow_tick_i) begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  // counts rc ticks while the key is invalid
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_cnt_ff <= '0;
    end else if (!key_bad || fault_fire) begin
      fault_cnt_ff <= '0;
    end else if (rc_tick_i) begin
      fault_cnt_ff <= fault_cnt_ff + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // reset flag register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      key_fault_ff <= 1'b0;
      vsel_fault_ff <= 1'b0;
      brownout_ff <= 1'b0;
      idle_keep_ff <= 1'b0;
    end else begin
      if (wr_flags) begin
        idle_keep_ff <= bus.wdata[BIT_IDLE_KEEP];
        // flags take only a zero from software
        if (!bus.wdata[BIT_KEY_FAULT]) begin
          key_fault_ff <= 1'b0;
        end
        if (!bus.wdata[BIT_VSEL_FAULT]) begin
          vsel_fault_ff <= 1'b0;
        end
        if (!bus.wdata[BIT_BROWNOUT]) begin
          brownout_ff <= 1'b0;
        end
      end
      if (fault_fire) begin
        key_fault_ff <= 1'b1;
      end
      if (vsel_fault_evt_i) begin
        vsel_fault_ff <= 1'b1;
      end
      if (brownout_evt_i) begin
        brownout_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      expiry_ff <= 1'b0;
      powerdown_ff <= 1'b0;
    end else begin
      if (overflow) begin
        expiry_ff <= 1'b1;
      end else if (cpu.halt || cpu.kick) begin
        expiry_ff <= 1'b0;
      end
      if (cpu.halt) begin
        powerdown_ff <= 1'b1;
      end else if (cpu.kick) begin
        powerdown_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
    end else begin
      if (wr_mask) begin
        irq_mask_ff <= bus.wdata[IRQ_W-1:0];
      end
      if (rd_irq) begin
        irq_stat_ff <= irq_evt; // set wins over read clear
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_evt;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    case (bus.addr)
      ADDR_WDT_CTRL: nxt_rdata = ctrl_ff;
      ADDR_RST_FLAGS: begin
        nxt_rdata[BIT_IDLE_KEEP] = idle_keep_ff;
        nxt_rdata[BIT_BROWNOUT] = brownout_ff;
        nxt_rdata[BIT_VSEL_FAULT] = vsel_fault_ff;
        nxt_rdata[BIT_KEY_FAULT] = key_fault_ff; // bits 6..3 stay zero
      end
      ADDR_STATUS: begin
        nxt_rdata[BIT_EXPIRY] = expiry_ff;
        nxt_rdata[BIT_POWERDOWN] = powerdown_ff;
      end
      ADDR_IRQ_STAT: nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
      ADDR_IRQ_MASK: nxt_rdata[IRQ_W-1:0] = irq_mask_ff;
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= bus.rd ? nxt_rdata : '0;
    end
  end

  // ---------------------------------------------------------------
  // reset, wake and clock-enable outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dev_rst_ff <= 1'b0;
      pcsp_rst_ff <= 1'b0;
      wake_ff <= 1'b0;
      slow_en_ff <= 1'b1;
      irq_ff <= 1'b0;
    end else begin
      dev_rst_ff <= fault_fire || (overflow && state_ff == ST_RUN);
      pcsp_rst_ff <= overflow && state_ff == ST_SLEEP;
      wake_ff <= overflow && state_ff == ST_SLEEP;
      slow_en_ff <= wdt_on || key_bad;
      irq_ff <= |((irq_stat_ff | irq_evt) & irq_mask_ff);
    end
  end

  assign rdata_o = rdata_ff;
  assign device_reset_o = dev_rst_ff;
  assign pc_sp_reset_o = pcsp_rst_ff;
  assign wake_o = wake_ff;
  assign slow_clk_en_o = slow_en_ff;
  assign idle_sysclk_keep_o = idle_keep_ff;
  assign irq_o = irq_ff;
endmodule

// File: verification/keyed_watchdog_timer_tb.sv
// testbench: register and counter scenarios for the keyed watchdog
`timescale 1ns/100ps
module keyed_watchdog_timer_tb;
  import kwdt_pkg::*;
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic slow_tick_i = 1'b0;
  logic rc_tick_i = 1'b0;
  logic halt_i = 1'b0;
  logic kick_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic [DATA_W-1:0] rdata_o;
  logic device_reset_o, pc_sp_reset_o, wake_o, slow_clk_en_o, idle_sysclk_keep_o, irq_o;
  int n_fail = 0;
  int checks_done = 0;
  int n_rst = 0;
  int n_pcsp = 0;
  int n_wake = 0;
  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    n_rst += (device_reset_o === 1'b1);
    n_pcsp += (pc_sp_reset_o === 1'b1);
    n_wake += (wake_o === 1'b1);
  end
  kwdt_top kwdt_top_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .slow_tick_i(slow_tick_i), .rc_tick_i(rc_tick_i), .src_is_crystal_i(1'b0),
    .halt_i(halt_i), .kick_i(kick_i), .idle_mode_i(1'b0), .brownout_evt_i(1'b0),
    .vsel_fault_evt_i(1'b0), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .device_reset_o(device_reset_o),
    .pc_sp_reset_o(pc_sp_reset_o), .wake_o(wake_o), .slow_clk_en_o(slow_clk_en_o),
    .idle_sysclk_keep_o(idle_sysclk_keep_o), .irq_o(irq_o));
  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                    input logic [DATA_W-1:0] m);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o & m, e);
  endtask
  // which: 0 slow tick, 1 rc tick, 2 kick, 3 halt, 4 kick with slow tick
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      case (which)
        0: slow_tick_i <= 1'b1;
        1: rc_tick_i <= 1'b1;
        2: kick_i <= 1'b1;
        4: {kick_i, slow_tick_i} <= 2'h3;
        default: halt_i <= 1'b1;
      endcase
      @(posedge core_clk_i);
      {slow_tick_i, rc_tick_i, kick_i, halt_i} <= 4'h0;
    end
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  task automatic results();
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (2) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    rd(ADDR_WDT_CTRL, WDT_CTRL_RESET, 8'hFF);
    rd(ADDR_RST_FLAGS, 8'h00, 8'h78);
    check(slow_clk_en_o, 1'b1);
    wr(ADDR_IRQ_MASK, 8'h07);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_WDT_CTRL, {KEY_ENABLE, 3'(i)});
      check(irq_o, 1'b0);
      pulse(2, 1);
      rd(ADDR_STATUS, 8'h00, 8'h03);
      pulse(0, 200);
      pulse(2, 1);
      pulse(0, (256 << (2 * i)) - 1);
      check(n_rst, i);
      pulse(0, 1);
      check(n_rst, i + 1);
      check(irq_o, 1'b1);
      rd(ADDR_STATUS, 8'h01, 8'h03);
      rd(ADDR_IRQ_STAT, 8'h01, 8'h07);
    end
    wr(ADDR_WDT_CTRL, {KEY_DISABLE, 3'h0});
    check(irq_o, 1'b0);
    rd(ADDR_WDT_CTRL, 8'hA8, 8'hFF);
    pulse(0, 300);
    check(n_rst, 2);
    check(n_wake, 0);
    check(slow_clk_en_o, 1'b0);
    wr(ADDR_WDT_CTRL, {KEY_ENABLE, 3'h0});
    pulse(3, 1);
    rd(ADDR_STATUS, 8'h02, 8'h03);
    pulse(0, 256);
    check(n_pcsp, 1);
    check(n_wake, 1);
    check(n_rst, 2);
    rd(ADDR_STATUS, 8'h03, 8'h03);
    rd(ADDR_IRQ_STAT, 8'h04, 8'h04);
    pulse(2, 1);
    rd(ADDR_STATUS, 8'h00, 8'h03);
    wr(ADDR_WDT_CTRL, {5'h1F, 3'h0});
    pulse(1, 1);
    check(n_rst, 2);
    pulse(1, 2);
    check(n_rst, 3);
    wr(ADDR_WDT_CTRL, {KEY_ENABLE, 3'h0});
    rd(ADDR_RST_FLAGS, 8'h01, 8'h79);
    rd(ADDR_IRQ_STAT, 8'h02, 8'h02);
    wr(ADDR_RST_FLAGS, 8'hFF);
    check(idle_sysclk_keep_o, 1'b1);
    rd(ADDR_RST_FLAGS, 8'h01, 8'h01);
    wr(ADDR_RST_FLAGS, 8'h00);
    check(idle_sysclk_keep_o, 1'b0);
    rd(ADDR_RST_FLAGS, 8'h00, 8'h01);
    pulse(0, 255);
    pulse(4, 1);
    check(n_rst, 3);
    rd(ADDR_STATUS, 8'h00, 8'h03);
    pulse(0, 255);
    check(n_rst, 3);
    pulse(0, 1);
    check(n_rst, 4);
    results();
  end
  initial begin
    #2_000_000;
    n_fail++;
    results();
  end
endmodule

// File: verification/kwdt_chk.sv
// checker: port-level assertions for the keyed watchdog
`timescale 1ns/100ps
module kwdt_chk
  import kwdt_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic slow_tick_i,
  input wire logic rc_tick_i,
  input wire logic halt_i,
  input wire logic kick_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic device_reset_o,
  input wire logic pc_sp_reset_o,
  input wire logic wake_o
);
  // ----
  // assertions
  // ----
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_rdata_idle;
    !$past(rd_i) |-> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_flags_unimpl;
    $past(rd_i) && $past(addr_i) == ADDR_RST_FLAGS |-> rdata_o[6:3] == 4'h0;
  endproperty
  a_flags_unimpl: assert property (p_flags_unimpl) else $error("flag bits 6..3 set");
  property p_wake_pair;
    wake_o == pc_sp_reset_o;
  endproperty
  a_wake_pair: assert property (p_wake_pair) else $error("wake not with pc reset");
  property p_one_kind;
    !(device_reset_o && pc_sp_reset_o);
  endproperty
  a_one_kind: assert property (p_one_kind) else $error("both reset kinds at once");
  property p_rst_pulse;
    device_reset_o |=> !device_reset_o;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("device reset too long");
  property p_rst_cause;
    device_reset_o |-> $past(slow_tick_i) || $past(rc_tick_i);
  endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("reset without tick");
  property p_pcsp_cause;
    pc_sp_reset_o |-> $past(slow_tick_i);
  endproperty
  a_pcsp_cause: assert property (p_pcsp_cause) else $error("pc reset without tick");
  property p_kick_clear;
    kick_i && !rc_tick_i |=> !device_reset_o;
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("reset after kick");
  property p_halt_clear;
    halt_i && !rc_tick_i |=> !device_reset_o && !pc_sp_reset_o;
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("reset after halt");
endmodule
bind kwdt_top kwdt_chk kwdt_chk_inst (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .slow_tick_i(slow_tick_i), .rc_tick_i(rc_tick_i), .halt_i(halt_i), .kick_i(kick_i),
  .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .device_reset_o(device_reset_o),
  .pc_sp_reset_o(pc_sp_reset_o), .wake_o(wake_o));
